// ---- rtl/safety_test_stop_map.svh ----
/*
 * Constants of the test stop monitor: codes, reset values, time base.
 * Assumes inclusion from the package and the monitor module only.
 */
`ifndef SAFETY_TEST_STOP_MAP_SVH
`define SAFETY_TEST_STOP_MAP_SVH

// ==================================================================
// Setting codes and reset values
`define COPY_START_CODE 8'hD0
`define CHANGE_CONFIRM_CODE 8'hDC
`define CHANGE_CONFIRM_RESET 8'h00
`define SAVE_START_VALUE 1'h1
`define PASSWORD_RESET 32'h0000_0000
`define FILTER_READY 8'h00
`define FILTER_RESET 8'h00

// ==================================================================
// Status word bit positions
`define STATUS_TEST_REQUIRED_BIT 31
`define STATUS_TORQUE_OFF_BIT 1

// ==================================================================
// Time base: timer runs in whole seconds
`define TEST_INTERVAL_DEFAULT_H 8
`define SECONDS_PER_HOUR 3600
`define CLK_FREQ_HZ 200000000
`define TICK_PERIOD_S 1

`endif

// ---- rtl/safety_test_stop_monitor.sv ----
/*
 * Forced self test monitor for the torque switch-off paths, with the
 * commissioning controls (copy, confirm, save, password, filter).
 * Assumes all inputs synchronous to core_clk and pulses one cycle wide.
 */
// Functional notes
// - Every selection of the torque off function made while no self test runs starts the forced self test.
// - With an external brake relay fitted, the self test also checks its circuits.
// - A timer with configurable period, default eight hours, watches the test interval.
// - The remaining time until the next self test is readable.
// - Status word bit 31 is one while a self test is required.
// - Writing D0 hex to copy control starts the redundant parameter copy.
// - Writing DC hex to change confirm acknowledges a change; default zero.
// - Writing one to save trigger saves; it reads zero once saving is done.
// - Activation with the default password demands a password change.
// - An impermissible password is rejected; the old password stays.
// - Commissioning filter written to zero puts the device in ready state.
// - Only passwords one to FFFF FFFF are valid; zero is invalid.
// - Status word bit 1 is one while torque off is active.
`timescale 1ns/1ps
`include "safety_test_stop_map.svh"

module safety_test_stop_monitor
    import safety_test_stop_pkg::*;
#(
    // Cycles per one-second tick; shorten in simulation
    parameter int unsigned TICK_CYCLES = `CLK_FREQ_HZ * `TICK_PERIOD_S
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Torque off and self test paths
    input wire logic torqueOffSelect,
    input wire logic brakeRelayFitted,
    input wire logic pathTestOk,
    input wire logic brakeTestOk,
    output logic pathTestStart,
    output logic brakeTestStart,
    // Monitoring timer and status
    input wire settingWrite_t test_interval_setting_wr,
    output logic [31:0] testIntervalSetting,
    output logic [31:0] testTimeRemaining,
    output statusWord_t safetyStatusWord,
    // Commissioning controls
    input wire settingWrite_t safety_copy_control_wr,
    input wire settingWrite_t safety_change_confirm_wr,
    input wire settingWrite_t nonvolatile_save_trigger_wr,
    input wire settingWrite_t password_entry_wr,
    input wire settingWrite_t commissioning_filter_wr,
    input wire logic nvSaveDone,
    input wire logic activationRequest,
    output logic copyStart,
    output logic changeConfirmed,
    output logic [7:0] safetyChangeConfirm,
    output logic saveTrigger,
    output logic [31:0] passwordEntry,
    output logic passwordChangeRequired,
    output logic [7:0] commissioningFilter,
    output logic commissioningReady
);

    localparam logic [31:0] INTERVAL_DEFAULT_S = 32'(`TEST_INTERVAL_DEFAULT_H * `SECONDS_PER_HOUR);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    // ==================================================================
    // Self test sequence
    testState_t state, next_state;
    logic selectPrev, next_pathTestStart, next_brakeTestStart, testPass;

    always_comb begin
        next_state = state;
        next_pathTestStart = 1'b0;
        next_brakeTestStart = 1'b0;
        testPass = 1'b0;
        case (state)
            TEST_IDLE: begin
                if (torqueOffSelect && !selectPrev) begin
                    next_state = TEST_PATHS;
                    next_pathTestStart = 1'b1;
                end
            end
            TEST_PATHS: begin
                if (pathTestOk) begin
                    if (brakeRelayFitted) begin
                        next_state = TEST_BRAKE;
                        next_brakeTestStart = 1'b1;
                    end else begin
                        next_state = TEST_IDLE;
                        testPass = 1'b1;
                    end
                end
            end
            TEST_BRAKE: begin
                if (brakeTestOk) begin
                    next_state = TEST_IDLE;
                    testPass = 1'b1;
                end
            end
            default: next_state = TEST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TEST_IDLE;
            selectPrev <= 1'b0;
            pathTestStart <= 1'b0;
            brakeTestStart <= 1'b0;
        end else begin
            state <= next_state;
            selectPrev <= torqueOffSelect;
            pathTestStart <= next_pathTestStart;
            brakeTestStart <= next_brakeTestStart;
        end
    end

    // ==================================================================
    // Monitoring timer in whole seconds
    logic [31:0] tickCnt, next_tickCnt, next_interval, next_remaining;
    logic tickNow, next_testRequired;
    statusWord_t next_status;

    always_comb begin
        tickNow = (tickCnt == TICK_LAST);
        next_tickCnt = tickNow ? 32'h0000_0000 : tickCnt + 32'h0000_0001;
        next_interval = test_interval_setting_wr.strobe ? test_interval_setting_wr.value
                                                        : testIntervalSetting;
        // A new period takes effect at the next reload, not mid-interval
        next_remaining = testTimeRemaining;
        next_testRequired = safetyStatusWord.testRequired;
        if (testPass) begin
            next_remaining = testIntervalSetting;
            next_testRequired = 1'b0;
        end else if (testTimeRemaining == 32'h0000_0000) begin
            next_testRequired = 1'b1;
        end else if (tickNow) begin
            next_remaining = testTimeRemaining - 32'h0000_0001;
        end
        next_status = '0;
        next_status.testRequired = next_testRequired;
        next_status.torqueOffActive = torqueOffSelect;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt <= 32'h0000_0000;
            testIntervalSetting <= INTERVAL_DEFAULT_S;
            testTimeRemaining <= INTERVAL_DEFAULT_S;
            safetyStatusWord <= '0;
        end else begin
            tickCnt <= next_tickCnt;
            testIntervalSetting <= next_interval;
            testTimeRemaining <= next_remaining;
            safetyStatusWord <= next_status;
        end
    end

    // ==================================================================
    // Commissioning controls
    logic next_copyStart, next_changeConfirmed, next_saveTrigger, next_pwChange, next_ready;
    logic [7:0] next_confirm, next_filter;
    logic [31:0] next_password;
    logic pwValid;

    always_comb begin
        next_copyStart = safety_copy_control_wr.strobe &&
                         (safety_copy_control_wr.value[7:0] == `COPY_START_CODE);
        next_confirm = safety_change_confirm_wr.strobe ? safety_change_confirm_wr.value[7:0]
                                                       : safetyChangeConfirm;
        next_changeConfirmed = safety_change_confirm_wr.strobe &&
                               (safety_change_confirm_wr.value[7:0] == `CHANGE_CONFIRM_CODE);
        // A new save request wins over a completion seen in the same cycle
        next_saveTrigger = saveTrigger;
        if (nonvolatile_save_trigger_wr.strobe &&
            nonvolatile_save_trigger_wr.value[0] == `SAVE_START_VALUE) begin
            next_saveTrigger = 1'b1;
        end else if (nvSaveDone) begin
            next_saveTrigger = 1'b0;
        end
        pwValid = (password_entry_wr.value != `PASSWORD_RESET);
        next_password = (password_entry_wr.strobe && pwValid) ? password_entry_wr.value
                                                              : passwordEntry;
        next_pwChange = passwordChangeRequired;
        if (activationRequest && passwordEntry == `PASSWORD_RESET) begin
            next_pwChange = 1'b1;
        end else if (password_entry_wr.strobe && pwValid) begin
            next_pwChange = 1'b0;
        end
        next_filter = commissioning_filter_wr.strobe ? commissioning_filter_wr.value[7:0]
                                                     : commissioningFilter;
        next_ready = (next_filter == `FILTER_READY);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            copyStart <= 1'b0;
            changeConfirmed <= 1'b0;
            safetyChangeConfirm <= `CHANGE_CONFIRM_RESET;
            saveTrigger <= 1'b0;
            passwordEntry <= `PASSWORD_RESET;
            passwordChangeRequired <= 1'b0;
            commissioningFilter <= `FILTER_RESET;
            commissioningReady <= 1'b1;
        end else begin
            copyStart <= next_copyStart;
            changeConfirmed <= next_changeConfirmed;
            safetyChangeConfirm <= next_confirm;
            saveTrigger <= next_saveTrigger;
            passwordEntry <= next_password;
            passwordChangeRequired <= next_pwChange;
            commissioningFilter <= next_filter;
            commissioningReady <= next_ready;
        end
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence selectRise;
        state == TEST_IDLE && torqueOffSelect && !selectPrev;
    endsequence
    sequence pathsPassBrake;
        state == TEST_PATHS && pathTestOk && brakeRelayFitted;
    endsequence
    sequence confirmWrite;
        safety_change_confirm_wr.strobe && safety_change_confirm_wr.value[7:0] == `CHANGE_CONFIRM_CODE;
    endsequence

    test_start_a: assert property (selectRise |=> state == TEST_PATHS && pathTestStart)
        else $error("Torque off selection did not start the self test");
    brake_step_a: assert property (pathsPassBrake |=> state == TEST_BRAKE && brakeTestStart
                                   ##1 state == TEST_BRAKE || state == TEST_IDLE)
        else $error("Brake relay circuits were not tested");
    timer_reload_a: assert property (testPass |=> testTimeRemaining == $past(testIntervalSetting)
                                     && !safetyStatusWord.testRequired)
        else $error("Passed self test did not reload the timer");
    remain_count_a: assert property (tickNow && !testPass && testTimeRemaining != 32'h0000_0000
                                     |=> testTimeRemaining == $past(testTimeRemaining) - 32'h0000_0001)
        else $error("Remaining time did not count down on the tick");
    status_due_a: assert property (testTimeRemaining == 32'h0000_0000 && !testPass
                                   |=> safetyStatusWord[`STATUS_TEST_REQUIRED_BIT])
        else $error("Required bit not raised at timer zero");
    due_holds_a: assert property (safetyStatusWord.testRequired && !testPass
                                  |=> safetyStatusWord.testRequired)
        else $error("Required bit dropped without a self test");
    copy_code_a: assert property (safety_copy_control_wr.strobe
                                  |=> copyStart == ($past(safety_copy_control_wr.value[7:0]) == `COPY_START_CODE))
        else $error("Copy start does not match the written code");
    // Confirming writes back to back legally stretch the pulse
    confirm_code_a: assert property (confirmWrite |=> changeConfirmed
                                     ##1 (!changeConfirmed || $past(safety_change_confirm_wr.strobe
                                     && safety_change_confirm_wr.value[7:0] == `CHANGE_CONFIRM_CODE)))
        else $error("Change confirmation pulse wrong");
    save_clear_a: assert property (saveTrigger && nvSaveDone && !nonvolatile_save_trigger_wr.strobe
                                   |=> !saveTrigger)
        else $error("Save trigger not cleared after save");
    password_keep_a: assert property (password_entry_wr.strobe && password_entry_wr.value == 32'h0000_0000
                                      |=> $stable(passwordEntry))
        else $error("Invalid password was stored");
    pw_change_a: assert property (activationRequest && passwordEntry == `PASSWORD_RESET
                                  |=> passwordChangeRequired)
        else $error("Default password not flagged on activation");
    filter_ready_a: assert property (commissioning_filter_wr.strobe
                                     && commissioning_filter_wr.value[7:0] == `FILTER_READY |=> commissioningReady)
        else $error("Filter zero did not give ready");
    sto_bit_a: assert property (torqueOffSelect |=> safetyStatusWord[`STATUS_TORQUE_OFF_BIT])
        else $error("Torque off bit not set");

endmodule

// ---- rtl/safety_test_stop_pkg.sv ----
/*
 * Types shared by the test stop monitor and its bench.
 * Assumes the constant header safety_test_stop_map.svh.
 */
package safety_test_stop_pkg;

    // ==================================================================
    // Self test sequence, coded 0, 1 and 3
    typedef enum logic [1:0] {
        TEST_IDLE = 2'h0,
        TEST_PATHS = 2'h1,
        TEST_BRAKE = 2'h3
    } testState_t;

    // ==================================================================
    // One write to a setting: strobe with its value
    typedef struct packed {
        logic strobe;
        logic [31:0] value;
    } settingWrite_t;

    typedef struct packed {
        logic testRequired;
        logic [28:0] reserved;
        logic torqueOffActive;
        logic spare;
    } statusWord_t;

endpackage

// ---- test/self_test_partner.sv ----
/*
 * Behavioural model of the circuits exercised by the forced self test.
 * Assumes start pulses of one core_clk cycle; answers after a lag chosen by the bench.
 */
`timescale 1ns/1ps

module self_test_partner (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Test requests and answers
    input wire logic pathTestStart,
    input wire logic brakeTestStart,
    input wire logic [1:0] lag,
    output logic pathTestOk,
    output logic brakeTestOk
);
    // ==================================================================
    // Countdown per test step; an answer is a single-cycle pulse
    int pathCount;
    int brakeCount;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pathTestOk <= 1'b0;
            brakeTestOk <= 1'b0;
            pathCount = 0;
            brakeCount = 0;
        end else begin
            pathTestOk <= 1'b0;
            brakeTestOk <= 1'b0;
            if (pathTestStart) begin
                pathCount = lag + 1;
            end else if (pathCount != 0) begin
                pathCount = pathCount - 1;
                pathTestOk <= (pathCount == 0);
            end
            if (brakeTestStart) begin
                brakeCount = lag + 1;
            end else if (brakeCount != 0) begin
                brakeCount = brakeCount - 1;
                brakeTestOk <= (brakeCount == 0);
            end
        end
    end
endmodule

// ---- test/tb.sv ----
/*
 * Self-checking bench of the test stop monitor with random lags and values.
 * Assumes the partner model answers the self test starts; tick shortened to 4 cycles.
 */
`timescale 1ns/1ps

module tb;
    import safety_test_stop_pkg::*;

    // ==================================================================
    // Stimulus and observation
    logic core_clk = 1'b0, rst_n = 1'b0, torqueOffSelect = 1'b0, brakeRelayFitted = 1'b0;
    logic pathTestOk, brakeTestOk, pathTestStart, brakeTestStart, nvSaveDone = 1'b0;
    logic activationRequest = 1'b0, copyStart, changeConfirmed, saveTrigger, passwordChangeRequired;
    logic commissioningReady;
    logic [1:0] lag = 2'h0;
    logic [7:0] safetyChangeConfirm, commissioningFilter;
    logic [31:0] testIntervalSetting, testTimeRemaining, passwordEntry, interval, code;
    statusWord_t safetyStatusWord;
    settingWrite_t wInt = '0, wCopy = '0, wConf = '0, wSave = '0, wPw = '0, wFilt = '0;
    int n_errors = 0, total_checks = 0, cycles = 0, seed = 28;

    safety_test_stop_monitor #(.TICK_CYCLES(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .torqueOffSelect(torqueOffSelect), .brakeRelayFitted(brakeRelayFitted), .pathTestOk(pathTestOk),
        .brakeTestOk(brakeTestOk), .pathTestStart(pathTestStart), .brakeTestStart(brakeTestStart),
        .test_interval_setting_wr(wInt), .testIntervalSetting(testIntervalSetting),
        .testTimeRemaining(testTimeRemaining), .safetyStatusWord(safetyStatusWord),
        .safety_copy_control_wr(wCopy), .safety_change_confirm_wr(wConf), .nonvolatile_save_trigger_wr(wSave),
        .password_entry_wr(wPw), .commissioning_filter_wr(wFilt), .nvSaveDone(nvSaveDone),
        .activationRequest(activationRequest), .copyStart(copyStart), .changeConfirmed(changeConfirmed),
        .safetyChangeConfirm(safetyChangeConfirm), .saveTrigger(saveTrigger), .passwordEntry(passwordEntry),
        .passwordChangeRequired(passwordChangeRequired), .commissioningFilter(commissioningFilter),
        .commissioningReady(commissioningReady));
    self_test_partner partner (.core_clk(core_clk), .rst_n(rst_n), .pathTestStart(pathTestStart),
        .brakeTestStart(brakeTestStart), .lag(lag), .pathTestOk(pathTestOk), .brakeTestOk(brakeTestOk));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    // ==================================================================
    // Checking, expectations and closing
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    function automatic logic code_hit(input logic [31:0] v, input logic [7:0] c);
        return v[7:0] == c;
    endfunction

    task stop_test;
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence takes well under 1000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            stop_test;
        end
    end

    // ==================================================================
    // Drivers: strobe is set on one falling edge, cleared on the next
    task wr(input int k, input logic [31:0] v);
        settingWrite_t s;
        s = {1'b1, v};
        @(negedge core_clk);
        case (k)
            0: wInt = s;
            1: wCopy = s;
            2: wConf = s;
            3: wSave = s;
            4: wPw = s;
            default: wFilt = s;
        endcase
        @(negedge core_clk);
        {wInt.strobe, wCopy.strobe, wConf.strobe, wSave.strobe, wPw.strobe, wFilt.strobe} = 6'h00;
    endtask

    task run_test(input logic fitted);
        int i;
        brakeRelayFitted = fitted;
        lag = 2'($random(seed));
        torqueOffSelect = 1'b1;
        for (i = 0; i < 20 && pathTestStart !== 1'b1; i++) @(negedge core_clk);
        chk(pathTestStart, 1'b1, "self test not started");
        chk(safetyStatusWord.torqueOffActive, 1'b1, "torque off bit");
        for (i = 0; i < 20 && pathTestOk !== 1'b1; i++) @(negedge core_clk);
        if (fitted) begin
            for (i = 0; i < 20 && brakeTestStart !== 1'b1; i++) @(negedge core_clk);
            chk(brakeTestStart, 1'b1, "brake circuits not tested");
            for (i = 0; i < 20 && brakeTestOk !== 1'b1; i++) @(negedge core_clk);
        end
        @(negedge core_clk);
        chk(testTimeRemaining, interval, "timer not reloaded");
        chk(safetyStatusWord.testRequired, 1'b0, "required bit not cleared");
        torqueOffSelect = 1'b0;
        @(negedge core_clk);
        chk(safetyStatusWord.torqueOffActive, 1'b0, "torque off bit after deselect");
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        chk(testIntervalSetting, 32'h0000_7080, "default period");
        chk(safetyChangeConfirm, 32'h0000_0000, "confirm default");
        chk(safetyStatusWord, 32'h0000_0000, "status after reset");
        interval = 32'h0000_0002 + ($random(seed) & 32'h0000_0003);
        wr(0, interval);
        chk(testIntervalSetting, interval, "period write");
        run_test(1'b0);
        repeat (5) @(negedge core_clk);
        chk(testTimeRemaining < interval, 1'b1, "remaining not counting");
        repeat (30) @(negedge core_clk);
        chk(testTimeRemaining, 32'h0000_0000, "timer not expired");
        chk(safetyStatusWord.testRequired, 1'b1, "test due not flagged");
        repeat (20) @(negedge core_clk);
        chk(safetyStatusWord.testRequired, 1'b1, "due flag dropped");
        run_test(1'b1);
        for (int k = 0; k < 4; k++) begin
            code = (k == 0) ? 32'h0000_00D0 : (k == 1) ? 32'h0000_00DC : $random(seed);
            wr(1, code);
            chk(copyStart, code_hit(code, 8'hD0), "copy start");
            wr(2, code);
            chk(changeConfirmed, code_hit(code, 8'hDC), "change confirm");
            chk(safetyChangeConfirm, code[7:0], "confirm stored");
        end
        wr(3, 32'h0000_0001);
        repeat (3) @(negedge core_clk);
        chk(saveTrigger, 1'b1, "save trigger");
        nvSaveDone = 1'b1;
        @(negedge core_clk);
        nvSaveDone = 1'b0;
        chk(saveTrigger, 1'b0, "save readback");
        activationRequest = 1'b1;
        @(negedge core_clk);
        activationRequest = 1'b0;
        chk(passwordChangeRequired, 1'b1, "password change demand");
        wr(4, 32'h0000_0000);
        chk(passwordEntry, 32'h0000_0000, "zero password kept");
        chk(passwordChangeRequired, 1'b1, "demand after reject");
        code = $random(seed) | 32'h0000_0001;
        wr(4, code);
        chk(passwordEntry, code, "password stored");
        chk(passwordChangeRequired, 1'b0, "demand cleared by valid password");
        wr(4, 32'hFFFF_FFFF);
        chk(passwordEntry, 32'hFFFF_FFFF, "top password");
        wr(5, 32'h0000_005F);
        chk(commissioningReady, 1'b0, "filter set");
        chk(commissioningFilter, 32'h0000_005F, "filter stored");
        wr(5, 32'h0000_0000);
        chk(commissioningReady, 1'b1, "ready state");
        chk(commissioningFilter, 32'h0000_0000, "filter zero stored");
        // Mid-run reset must bring back the default period and password
        rst_n = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        chk(testIntervalSetting, 32'h0000_7080, "default period after reset");
        chk(passwordEntry, 32'h0000_0000, "password after reset");
        chk(safetyStatusWord, 32'h0000_0000, "status after second reset");
        repeat (2) @(negedge core_clk);
        stop_test;
    end
endmodule
